// ### rtl/lsf_status_top.sv
// Purpose: Status and identification registers behind an I2C target port
// Assumes: SCL and SDA are asynchronous pins, conversion inputs are on CLK
// Notes:   CLK must run at least eight times the SCL rate
`timescale 1ns/1ps
// Behaviour
// - Sample-done sets when a conversion ends
// - Status read or nonzero write clears done
// - Bit 3 shows conversion overflow
// - Bit 1 sets after persistent above-limit run
// - Bit 0 sets after persistent below-limit run
// - Status indicators read-only, bits 15..4 zero
// - Status register resets to zero
// - Identity word at 0x11, bits 15..14 zero
// - Persistence code selects 1, 2, 4, 8
// - Event pin polarity follows configuration bit
module lsf_status_top #(
  parameter logic [6:0]  DEV_ADDR   = 7'h44,
  parameter logic [1:0]  ID_LOW     = 2'h1,   // Arbitrary value
  parameter logic [11:0] ID_HIGH    = 12'h0A5, // Arbitrary value
  parameter int          RES_MANT_W = 20,
  parameter int          THR_MANT_W = 12
) (
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  SCL_IN,
  input  wire logic                  SDA_IN,
  output logic                       SDA_OUT,
  output logic                       SDA_OE,
  output logic                       EVENT_PIN,
  input  wire logic                  EVENT_PIN_POLARITY,
  input  wire logic                  CONV_DONE,
  input  wire logic                  CONV_OVERFLOW,
  input  wire logic [3:0]            RESULT_EXPONENT,
  input  wire logic [RES_MANT_W-1:0] RESULT_MANTISSA,
  input  wire logic [3:0]            UPPER_LIMIT_EXPONENT,
  input  wire logic [THR_MANT_W-1:0] UPPER_LIMIT_MANTISSA,
  input  wire logic [3:0]            LOWER_LIMIT_EXPONENT,
  input  wire logic [THR_MANT_W-1:0] LOWER_LIMIT_MANTISSA,
  input  wire logic [1:0]            PERSIST_COUNT
);
  localparam int LIN_W = RES_MANT_W + 24;

  logic                      scl_s1, scl_s2, scl_d;
  logic                      sda_s1, sda_s2, sda_d;
  logic                      scl_rise, scl_fall, start_det, stop_det;
  lsf_pkg::lsf_i2c_state_type state_reg, state_next;
  logic [2:0]                cnt_reg, cnt_next;
  logic                      pend_reg, pend_next;
  logic                      ack_reg, ack_next;
  logic                      mack_reg, mack_next;
  logic                      rw_reg, rw_next;
  logic                      lo_reg, lo_next;
  logic                      low_reg, low_next;
  logic [7:0]                shift_reg, shift_next;
  logic [7:0]                ptr_reg, ptr_next;
  logic [7:0]                hi_reg, hi_next;
  logic [15:0]               rd_reg, rd_next;
  logic                      load_word, wr_clear, rd_clear;
  logic [15:0]               status_word, ident_word, word_sel;
  logic                      done_reg, done_next;
  logic                      ovr_reg, ovr_next;
  logic                      event_reg, event_next;
  logic [LIN_W-1:0]          res_lin, upper_lin, lower_lin;
  logic [1:0]                violate, limit_flag;

  // Pins pass two flops before any logic looks at them
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= SCL_IN;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= SDA_IN;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign scl_rise  = scl_s2 && !scl_d;
  assign scl_fall  = !scl_s2 && scl_d;
  assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_det  = scl_s2 && scl_d && !sda_d && sda_s2;

  assign status_word = {lsf_pkg::STATUS_RSVD, ovr_reg, done_reg, limit_flag[1], limit_flag[0]};
  assign ident_word  = {lsf_pkg::IDENT_RSVD, ID_LOW, ID_HIGH};

  always_comb begin
    word_sel = lsf_pkg::UNMAPPED_VALUE;
    if (ptr_reg == lsf_pkg::STATUS_OFFSET) begin
      word_sel = status_word;
    end else if (ptr_reg == lsf_pkg::IDENT_OFFSET) begin
      word_sel = ident_word;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg;
    ack_next   = ack_reg;
    mack_next  = mack_reg;
    rw_next    = rw_reg;
    lo_next    = lo_reg;
    low_next   = low_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    hi_next    = hi_reg;
    rd_next    = rd_reg;
    load_word  = 1'b0;
    wr_clear   = 1'b0;
    if (stop_det) begin
      state_next = lsf_pkg::LSF_IDLE;
      pend_next  = 1'b0;
      ack_next   = 1'b0;
      mack_next  = 1'b0;
      low_next   = 1'b0;
    end else if (start_det) begin
      state_next = lsf_pkg::LSF_ADDR;
      cnt_next   = 3'h0;
      pend_next  = 1'b0;
      ack_next   = 1'b0;
      mack_next  = 1'b0;
      lo_next    = 1'b0;
      low_next   = 1'b0;
    end else if (state_reg == lsf_pkg::LSF_RDATA) begin
      if (scl_rise) begin
        if (mack_reg) begin
          // Host NACK ends the read, ACK asks for the next byte
          mack_next = 1'b0;
          ack_next  = !sda_s2;
          if (sda_s2) begin
            state_next = lsf_pkg::LSF_IDLE;
          end
        end else begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == lsf_pkg::BIT_LAST) begin
            pend_next = 1'b1;
          end
        end
      end else if (scl_fall) begin
        if (pend_reg) begin
          pend_next = 1'b0;
          mack_next = 1'b1;
          low_next  = 1'b0;
        end else if (ack_reg) begin
          ack_next = 1'b0;
          cnt_next = 3'h0;
          if (lo_reg) begin
            shift_next = rd_reg[7:0];
            low_next   = !rd_reg[7];
            lo_next    = 1'b0;
          end else begin
            load_word  = 1'b1;
            rd_next    = word_sel;
            shift_next = word_sel[15:8];
            low_next   = !word_sel[15];
            lo_next    = 1'b1;
          end
        end else begin
          shift_next = {shift_reg[6:0], 1'b0};
          low_next   = !shift_reg[6];
        end
      end
    end else if (state_reg != lsf_pkg::LSF_IDLE) begin
      if (scl_rise && !ack_reg) begin
        shift_next = {shift_reg[6:0], sda_s2};
        cnt_next   = cnt_reg + 3'h1;
        if (cnt_reg == lsf_pkg::BIT_LAST) begin
          pend_next = 1'b1;
        end
      end else if (scl_fall && pend_reg) begin
        pend_next = 1'b0;
        ack_next  = 1'b1;
        low_next  = 1'b1;
        unique case (state_reg)
          lsf_pkg::LSF_ADDR: begin
            rw_next = shift_reg[0];
            if (shift_reg[7:1] != DEV_ADDR) begin
              state_next = lsf_pkg::LSF_IDLE;
              ack_next   = 1'b0;
              low_next   = 1'b0;
            end
          end
          lsf_pkg::LSF_PTR: begin
            ptr_next = shift_reg;
          end
          lsf_pkg::LSF_WDATA: begin
            if (!lo_reg) begin
              hi_next = shift_reg;
              lo_next = 1'b1;
            end else begin
              lo_next = 1'b0;
              // only a nonzero status write acts
              wr_clear = (ptr_reg == lsf_pkg::STATUS_OFFSET) && ({hi_reg, shift_reg} != 16'h0000);
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall && ack_reg) begin
        ack_next = 1'b0;
        low_next = 1'b0;
        cnt_next = 3'h0;
        unique case (state_reg)
          lsf_pkg::LSF_ADDR: begin
            if (rw_reg) begin
              state_next = lsf_pkg::LSF_RDATA;
              load_word  = 1'b1;
              rd_next    = word_sel;
              shift_next = word_sel[15:8];
              low_next   = !word_sel[15];
              lo_next    = 1'b1;
            end else begin
              state_next = lsf_pkg::LSF_PTR;
            end
          end
          lsf_pkg::LSF_PTR: begin
            state_next = lsf_pkg::LSF_WDATA;
            lo_next    = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= lsf_pkg::LSF_IDLE;
      cnt_reg   <= 3'h0;
      pend_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      mack_reg  <= 1'b0;
      rw_reg    <= 1'b0;
      lo_reg    <= 1'b0;
      low_reg   <= 1'b0;
      shift_reg <= 8'h00;
      ptr_reg   <= lsf_pkg::PTR_RESET;
      hi_reg    <= 8'h00;
      rd_reg    <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      ack_reg   <= ack_next;
      mack_reg  <= mack_next;
      rw_reg    <= rw_next;
      lo_reg    <= lo_next;
      low_reg   <= low_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      hi_reg    <= hi_next;
      rd_reg    <= rd_next;
    end
  end

  // Open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = low_reg;

  // Read clears at the moment the word is captured for sending
  assign rd_clear = load_word && (ptr_reg == lsf_pkg::STATUS_OFFSET);

  always_comb begin
    done_next = done_reg;
    ovr_next  = ovr_reg;
    if (rd_clear || wr_clear) begin
      done_next = 1'b0;
    end
    if (CONV_DONE) begin
      done_next = 1'b1;
      ovr_next  = CONV_OVERFLOW;
    end
    event_next = EVENT_PIN_POLARITY ? done_next : !done_next;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_reg  <= lsf_pkg::STATUS_RESET[lsf_pkg::DONE_BIT];
      ovr_reg   <= lsf_pkg::STATUS_RESET[lsf_pkg::OVR_BIT];
      event_reg <= 1'b1;
    end else begin
      done_reg  <= done_next;
      ovr_reg   <= ovr_next;
      event_reg <= event_next;
    end
  end

  assign EVENT_PIN = event_reg;

  // Linear scale; threshold mantissa aligns to the result's top bits
  assign res_lin   = LIN_W'(RESULT_MANTISSA) << RESULT_EXPONENT;
  assign upper_lin = LIN_W'(UPPER_LIMIT_MANTISSA) << (5'(UPPER_LIMIT_EXPONENT) + lsf_pkg::THR_ALIGN);
  assign lower_lin = LIN_W'(LOWER_LIMIT_MANTISSA) << (5'(LOWER_LIMIT_EXPONENT) + lsf_pkg::THR_ALIGN);
  assign violate[lsf_pkg::BELOW_BIT] = res_lin < lower_lin;
  assign violate[lsf_pkg::ABOVE_BIT] = res_lin > upper_lin;

  for (genvar i = 0; i < 2; i++) begin : g_limit
    lsf_persist u_persist (
      .clk          (CLK),
      .arst_n       (ARST_N),
      .conv_done    (CONV_DONE),
      .violate      (violate[i]),
      .persist_code (PERSIST_COUNT),
      .flag         (limit_flag[i])
    );
  end

  done_set_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    CONV_DONE |=> done_reg && status_word[lsf_pkg::DONE_BIT])
    else $error("sample-done not set after conversion");
  done_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (rd_clear || wr_clear) && !CONV_DONE |=> !done_reg)
    else $error("status access did not clear sample-done");
  ovr_follow_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    CONV_DONE |=> ovr_reg == $past(CONV_OVERFLOW))
    else $error("overrange does not match last conversion");
  rsvd_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    load_word |=> rd_reg[15:4] == 12'h000 || $past(ptr_reg) != lsf_pkg::STATUS_OFFSET)
    else $error("status reserved bits read nonzero");
  ident_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    load_word && ptr_reg == lsf_pkg::IDENT_OFFSET |=> rd_reg == {2'h0, ID_LOW, ID_HIGH} && shift_reg == rd_reg[15:8])
    else $error("identity word read wrong");
  event_pol_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    ##1 $stable(EVENT_PIN_POLARITY) |-> EVENT_PIN == (EVENT_PIN_POLARITY ? done_reg : !done_reg))
    else $error("event pin level disagrees with polarity");
  done_set_c: cover property (@(posedge CLK) disable iff (!ARST_N) $rose(done_reg));
  read_clear_c: cover property (@(posedge CLK) disable iff (!ARST_N) rd_clear ##1 !done_reg);
  write_clear_c: cover property (@(posedge CLK) disable iff (!ARST_N) wr_clear);
endmodule : lsf_status_top

// ### rtl/lsf_pkg.sv
// Purpose: Shared constants and types for the light sensor status flag block
// Assumes: 16-bit registers reached through an 8-bit register pointer
// Notes:   Bit positions are plain ints, widths sized where they meet logic
package lsf_pkg;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h0C;
  localparam logic [7:0]  IDENT_OFFSET    = 8'h11;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  localparam logic [15:0] UNMAPPED_VALUE  = 16'h0000;
  localparam int          BELOW_BIT       = 0;
  localparam int          ABOVE_BIT       = 1;
  localparam int          DONE_BIT        = 2;
  localparam int          OVR_BIT         = 3;
  localparam logic [11:0] STATUS_RSVD     = 12'h000;
  localparam logic [1:0]  IDENT_RSVD      = 2'h0;
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam logic [3:0]  PERSIST_RESET   = 4'h0;
  localparam logic [4:0]  THR_ALIGN       = 5'h08;

  typedef enum logic [2:0] {
    LSF_IDLE  = 3'b000,
    LSF_ADDR  = 3'b001,
    LSF_PTR   = 3'b011,
    LSF_WDATA = 3'b010,
    LSF_RDATA = 3'b110
  } lsf_i2c_state_type;
endpackage : lsf_pkg

// ### rtl/lsf_persist.sv
// Purpose: Consecutive out-of-limit counter and limit indicator
// Assumes: conv_done is a one-cycle pulse on clk
// Notes:   Counter saturates at eight, the largest run ever needed
`timescale 1ns/1ps
module lsf_persist (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       conv_done,
  input  wire logic       violate,
  input  wire logic [1:0] persist_code,
  output logic            flag
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       flag_reg;
  logic       flag_next;
  logic [3:0] need;
  logic [3:0] cnt_inc;

  assign need    = 4'h1 << persist_code;
  assign cnt_inc = (cnt_reg >= 4'h8) ? cnt_reg : cnt_reg + 4'h1;

  always_comb begin
    cnt_next  = cnt_reg;
    flag_next = flag_reg;
    if (conv_done) begin
      if (violate) begin
        cnt_next  = cnt_inc;
        flag_next = (cnt_inc >= need);
      end else begin
        cnt_next  = lsf_pkg::PERSIST_RESET;
        flag_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= lsf_pkg::PERSIST_RESET;
      flag_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  flag_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    conv_done && violate && (cnt_reg == 4'h0) && (persist_code == 2'h1) |=> !flag_reg && cnt_reg == 4'h1)
    else $error("limit flag set after one of two violations");
  run_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
    conv_done && !violate |=> cnt_reg == 4'h0 && !flag_reg)
    else $error("in-limit result did not restart the run");
  flag_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !conv_done |=> $stable(flag_reg) && $stable(cnt_reg))
    else $error("limit state moved without a conversion");
  flag_rise_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(flag_reg));
endmodule : lsf_persist

// ### sim/lsf_host_model.sv
// Purpose: I2C host that reaches the status block registers
// Assumes: SDA has a pull-up, SCL is driven only by this host
// Notes:   SCL stands still between frames, 320 ns per bit
`timescale 1ns/1ps
module lsf_host_model (
  output logic     scl,
  output logic     sda_pull,
  input  wire logic sda
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Long low phase leaves room for the target's synchroniser delay
  task automatic clk_bit(input logic tx, output logic rx);
    sda_pull = ~tx;
    #160;
    scl = 1'b1;
    #80;
    rx = sda;
    #80;
    scl = 1'b0;
  endtask : clk_bit

  task automatic start_cond();
    sda_pull = 1'b0;
    #160;
    scl = 1'b1;
    #80;
    sda_pull = 1'b1;
    #80;
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    sda_pull = 1'b1;
    #160;
    scl = 1'b1;
    #80;
    sda_pull = 1'b0;
    #160;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], r);
    end
    clk_bit(1'b1, nak);
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(last, r);
  endtask : recv_byte

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr, input logic [15:0] data,
                           output logic nak);
    logic n0, n1, n2, n3;
    start_cond();
    send_byte({addr, 1'b0}, n0);
    send_byte(ptr, n1);
    send_byte(data[15:8], n2);
    send_byte(data[7:0], n3);
    stop_cond();
    nak = n0 | n1 | n2 | n3;
  endtask : write_reg

  // Host polls status instead of the event pin
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr, output logic [15:0] data);
    logic n;
    start_cond();
    send_byte({addr, 1'b0}, n);
    send_byte(ptr, n);
    start_cond();
    send_byte({addr, 1'b1}, n);
    recv_byte(1'b0, data[15:8]);
    recv_byte(1'b1, data[7:0]);
    stop_cond();
  endtask : read_reg
endmodule : lsf_host_model

// ### sim/lsf_status_top_tb_top.sv
// Purpose: Self-checking bench for the status and identity registers
// Assumes: Thresholds upper 0x10000, lower 0x1000 after alignment
// Notes:   Registers only reached through the host model
`timescale 1ns/1ps
module lsf_status_top_tb_top;
  localparam logic [6:0]  ADDR = 7'h44;
  localparam logic [1:0]  IDL  = 2'h2;   // Arbitrary value
  localparam logic [11:0] IDH  = 12'h3C6; // Arbitrary value
  localparam logic [1:0]  MID  = 2'd0;
  localparam logic [1:0]  HI   = 2'd1;
  localparam logic [1:0]  LO   = 2'd2;
  typedef struct packed {logic ovf; logic [1:0] kind; logic [15:0] exp;} lsf_row_type;
  logic CLK, ARST_N, SDA_OUT, SDA_OE, EVENT_PIN, EVENT_PIN_POLARITY, CONV_DONE, CONV_OVERFLOW;
  logic [3:0]  RESULT_EXPONENT, UPPER_LIMIT_EXPONENT, LOWER_LIMIT_EXPONENT;
  logic [19:0] RESULT_MANTISSA;
  logic [11:0] UPPER_LIMIT_MANTISSA, LOWER_LIMIT_MANTISSA;
  logic [1:0]  PERSIST_COUNT;
  logic        host_scl, host_pull, nak;
  logic [15:0] rdata;
  wire         sda_line;
  int          n_fail, total_checks, cycles;
  lsf_row_type rows [6] = '{'{1'b0, LO, 16'h0004}, '{1'b1, LO, 16'h000D}, '{1'b0, MID, 16'h0004},
                            '{1'b0, HI, 16'h0004}, '{1'b1, HI, 16'h000E}, '{1'b0, LO, 16'h0004}};

  assign sda_line = ~host_pull & (SDA_OE ? SDA_OUT : 1'b1);

  lsf_host_model lsf_host_model_i (.scl(host_scl), .sda_pull(host_pull), .sda(sda_line));

  lsf_status_top #(.ID_LOW(IDL), .ID_HIGH(IDH)) lsf_status_top_i (
    .CLK                  (CLK),
    .ARST_N               (ARST_N),
    .SCL_IN               (host_scl),
    .SDA_IN               (sda_line),
    .SDA_OUT              (SDA_OUT),
    .SDA_OE               (SDA_OE),
    .EVENT_PIN            (EVENT_PIN),
    .EVENT_PIN_POLARITY   (EVENT_PIN_POLARITY),
    .CONV_DONE            (CONV_DONE),
    .CONV_OVERFLOW        (CONV_OVERFLOW),
    .RESULT_EXPONENT      (RESULT_EXPONENT),
    .RESULT_MANTISSA      (RESULT_MANTISSA),
    .UPPER_LIMIT_EXPONENT (UPPER_LIMIT_EXPONENT),
    .UPPER_LIMIT_MANTISSA (UPPER_LIMIT_MANTISSA),
    .LOWER_LIMIT_EXPONENT (LOWER_LIMIT_EXPONENT),
    .LOWER_LIMIT_MANTISSA (LOWER_LIMIT_MANTISSA),
    .PERSIST_COUNT        (PERSIST_COUNT)
  );

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // Ceiling well above the roughly 11400 cycles the sequence needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic conv(input logic ovf, input logic [1:0] kind);
    @(negedge CLK);
    CONV_DONE       = 1'b1;
    CONV_OVERFLOW   = ovf;
    RESULT_EXPONENT = (kind == HI) ? 4'h2 : 4'h0;
    RESULT_MANTISSA = (kind == LO) ? 20'h00800 : 20'h08000;
    @(negedge CLK);
    CONV_DONE = 1'b0;
    repeat (3) @(negedge CLK);
  endtask : conv

  task automatic rd(input logic [7:0] ptr);
    lsf_host_model_i.read_reg(ADDR, ptr, rdata);
  endtask : rd

  initial begin
    {n_fail, total_checks, cycles} = '0;
    {ARST_N, EVENT_PIN_POLARITY, CONV_DONE, CONV_OVERFLOW, PERSIST_COUNT} = '0;
    RESULT_EXPONENT      = 4'h0;
    RESULT_MANTISSA      = 20'h00000;
    UPPER_LIMIT_EXPONENT = 4'h0;
    UPPER_LIMIT_MANTISSA = 12'h100;
    LOWER_LIMIT_EXPONENT = 4'h0;
    LOWER_LIMIT_MANTISSA = 12'h010;
    repeat (12) @(negedge CLK);
    ARST_N = 1'b1;
    repeat (4) @(negedge CLK);
    rd(8'h0C);
    chk("status reset", 16'h0000, rdata);
    rd(8'h11);
    chk("identity", {2'b00, IDL, IDH}, rdata);
    // Each code: one short of the run, then the run, then an in-limit restart
    for (int c = 0; c < 4; c++) begin
      PERSIST_COUNT = c[1:0];
      for (int k = 0; k < (1 << c) - 1; k++) conv(1'b0, HI);
      rd(8'h0C);
      chk("run short", (c == 0) ? 16'h0000 : 16'h0004, rdata);
      conv(1'b0, HI);
      rd(8'h0C);
      chk("run full", 16'h0006, rdata);
      conv(1'b0, MID);
      rd(8'h0C);
      chk("run restart", 16'h0004, rdata);
    end
    PERSIST_COUNT = 2'd1;
    foreach (rows[i]) begin
      conv(rows[i].ovf, rows[i].kind);
      rd(8'h0C);
      chk("row status", rows[i].exp, rdata);
    end
    rd(8'h0C);
    chk("read clears done", 16'h0000, rdata);
    conv(1'b0, MID);
    chk("event active low", 16'h0000, {15'h0, EVENT_PIN});
    lsf_host_model_i.write_reg(ADDR, 8'h0C, 16'h0000, nak);
    rd(8'h0C);
    chk("zero write keeps", 16'h0004, rdata);
    chk("event released", 16'h0001, {15'h0, EVENT_PIN});
    conv(1'b0, MID);
    lsf_host_model_i.write_reg(ADDR, 8'h0C, 16'h0001, nak);
    rd(8'h0C);
    chk("nonzero write clears", 16'h0000, rdata);
    lsf_host_model_i.write_reg(ADDR, 8'h11, 16'hFFFF, nak);
    rd(8'h11);
    chk("identity read only", {2'b00, IDL, IDH}, rdata);
    rd(8'h05);
    chk("unmapped", 16'h0000, rdata);
    lsf_host_model_i.write_reg(7'h45, 8'h0C, 16'h0001, nak);
    chk("foreign address", 16'h0001, {15'h0, nak});
    @(negedge CLK);
    EVENT_PIN_POLARITY = 1'b1;
    conv(1'b1, HI);
    chk("event active high", 16'h0001, {15'h0, EVENT_PIN});
    ARST_N = 1'b0;
    repeat (3) @(negedge CLK);
    ARST_N = 1'b1;
    repeat (4) @(negedge CLK);
    rd(8'h0C);
    chk("mid-run reset", 16'h0000, rdata);
    end_of_test();
  end
endmodule : lsf_status_top_tb_top
